/* File: rtl/pldc_pkg.sv */
// Package with register map, field layout and reset values of the link drop and MAC config bank.
package pldc_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0]  IDX_LINK_DROP_CONFIG     = 8'h2d;
  localparam logic [7:0]  IDX_LINK_DROP_THRESHOLDS = 8'h2e;
  localparam logic [7:0]  IDX_MISC_CONFIG_FOUR     = 8'h31;
  localparam logic [7:0]  IDX_REDUCED_GMII_CONTROL = 8'h32;
  localparam logic [7:0]  IDX_IRQ_STATUS           = 8'h40;
  localparam logic [7:0]  IDX_IRQ_MASK             = 8'h41;
  localparam logic [11:0] ADDR_LINK_DROP_CONFIG     = {2'b00, IDX_LINK_DROP_CONFIG, 2'b00};
  localparam logic [11:0] ADDR_LINK_DROP_THRESHOLDS = {2'b00, IDX_LINK_DROP_THRESHOLDS, 2'b00};
  localparam logic [11:0] ADDR_MISC_CONFIG_FOUR     = {2'b00, IDX_MISC_CONFIG_FOUR, 2'b00};
  localparam logic [11:0] ADDR_REDUCED_GMII_CONTROL = {2'b00, IDX_REDUCED_GMII_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS           = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK             = {2'b00, IDX_IRQ_MASK, 2'b00};
  // Field positions.
  localparam int BIT_FORCE_DROP   = 15;
  localparam int BIT_FAST_DROP_EN = 14;
  localparam int LSB_CAUSE        = 8;
  localparam int BIT_INT_TEST     = 7;
  localparam int LSB_NEG_TIMER    = 5;
  localparam int LSB_RSV_MISC_CONFIG_FOUR     = 1;
  localparam int BIT_MIRROR       = 0;
  localparam int BIT_RGMII_EN     = 7;
  localparam int LSB_RX_HALF      = 5;
  localparam int LSB_TX_HALF      = 3;
  localparam int BIT_TX_SKEW      = 1;
  localparam int BIT_RX_SKEW      = 0;
  localparam int LSB_THR_RSV_HI   = 8;
  localparam int LSB_THR_RSV_LO   = 4;
  localparam int LSB_ENERGY_THR   = 0;
  localparam int BIT_MISC_CONFIG_FOUR_RSV     = 8;
  // Reset and fixed values.
  localparam logic [2:0] RST_ENERGY_THR       = 3'h1;
  localparam logic [2:0] RST_ENERGY_THR_STRAP = 3'h2;
  localparam logic [2:0] RST_THR_RSV          = 3'h2;
  localparam logic [1:0] RST_NEG_TIMER        = 2'h1;
  localparam logic [3:0] RSV_MISC_CONFIG_FOUR_VALUE       = 4'h8;
  localparam logic [1:0] RST_HALF_LEVEL       = 2'h2;
  localparam logic       RST_RGMII_EN         = 1'b1;
  // Negotiation timer durations in ns and their cycle counts at 50 MHz.
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_NEG_11_NS   = 11000000;
  localparam int T_NEG_10_NS   = 800000;
  localparam int T_NEG_01_NS   = 2000;
  localparam int T_NEG_00_NS   = 16000000;
  localparam int CYC_NEG_11    = T_NEG_11_NS / CLK_PERIOD_NS;
  localparam int CYC_NEG_10    = T_NEG_10_NS / CLK_PERIOD_NS;
  localparam int CYC_NEG_01    = T_NEG_01_NS / CLK_PERIOD_NS;
  localparam int CYC_NEG_00    = T_NEG_00_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       rgmii_enable;
    logic [1:0] rx_fifo_half_level;
    logic [1:0] tx_fifo_half_level;
    logic       tx_clock_skew_select;
    logic       rx_clock_skew_select;
  } pldc_mac_cfg_s;

  typedef struct packed {
    logic        force_partner_drop;
    logic        fast_drop_enable;
    logic [4:0]  drop_source_select;
    logic [2:0]  energy_loss_threshold;
    logic        internal_test_select;
    logic        mirror_mode_select;
    logic [31:0] negotiation_cycles;
  } pldc_line_cfg_s;

  typedef struct packed {
    logic       descrambler_sync_lost;
    logic       receive_errors;
    logic       mlt3_errors;
    logic       snr_low;
    logic [7:0] energy_level;
  } pldc_detect_s;
endpackage

/* File: rtl/pldc_regs.sv */
// Link drop and MAC interface configuration register bank with an APB slave.
`timescale 1ns/100ps
module pldc_regs (
  // APB slave.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Straps and package option.
  input  wire logic                    strap_fast_drop,
  input  wire logic                    strap_int_test,
  input  wire logic                    strap_mirror,
  input  wire logic                    strap_rgmii_en,
  input  wire logic                    package_fixed_rgmii,
  // Line-side detector inputs.
  input  wire pldc_pkg::pldc_detect_s  detect,
  input  wire logic                    no_signal,
  input  wire logic                    link_up,
  // Control outputs.
  output pldc_pkg::pldc_line_cfg_s     line_cfg,
  output pldc_pkg::pldc_mac_cfg_s      mac_cfg,
  output logic                         partner_drop_req,
  output logic                         link_drop,
  output logic                         irq
);
  import pldc_pkg::*;

  logic        force_drop_reg;
  logic        fast_en_reg;
  logic [4:0]  src_sel_reg;
  logic [4:0]  cause_reg;
  logic [4:0]  cause_next;
  logic [2:0]  energy_thr_reg;
  logic [2:0]  thr_rsv_hi_reg;
  logic [2:0]  thr_rsv_lo_reg;
  logic        misc_config_four_rsv8_reg;
  logic        int_test_reg;
  logic [1:0]  neg_timer_reg;
  logic        mirror_reg;
  pldc_mac_cfg_s mac_reg;
  logic [4:0]  irq_status_reg;
  logic [4:0]  irq_mask_reg;
  logic        strap_done_reg;
  logic [4:0]  criteria;
  logic [4:0]  fired;
  logic        access;
  logic        wr;
  logic        rd;
  logic [31:0] rdata_next;
  logic        bad_addr;
  logic [31:0] neg_cycles;

  // A transfer is taken in its first access cycle; the registered pready then ends it.
  assign access = psel & penable & ~pready;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;

  // The energy comparison is the only criterion computed here; the rest come from detectors.
  assign criteria = {detect.descrambler_sync_lost, detect.receive_errors,
                     detect.mlt3_errors, detect.snr_low,
                     (detect.energy_level < {5'h00, energy_thr_reg})};
  assign fired    = criteria & src_sel_reg & {5{fast_en_reg & link_up}};

  // Read-clear loses to a criterion still firing in the same cycle.
  always_comb begin
    cause_next = cause_reg;
    if (rd && paddr == ADDR_LINK_DROP_CONFIG) begin
      cause_next = 5'h00;
    end
    cause_next = cause_next | fired;
  end

  // The setting leaves as a cycle count, so the negotiator needs no decoder of its own.
  always_comb begin
    unique case (neg_timer_reg)
      2'b11: neg_cycles = CYC_NEG_11;
      2'b10: neg_cycles = CYC_NEG_10;
      2'b01: neg_cycles = CYC_NEG_01;
      2'b00: neg_cycles = CYC_NEG_00;
    endcase
  end

  // Unmapped offsets read zero and raise pslverr with the same ready.
  always_comb begin
    rdata_next = 32'h0000_0000;
    bad_addr   = 1'b0;
    unique case (paddr)
      ADDR_LINK_DROP_CONFIG: begin
        rdata_next[BIT_FORCE_DROP]          = force_drop_reg;
        rdata_next[BIT_FAST_DROP_EN]        = fast_en_reg;
        rdata_next[LSB_CAUSE +: 5]          = cause_reg;
        rdata_next[4:0]                     = src_sel_reg;
      end
      ADDR_LINK_DROP_THRESHOLDS: begin
        rdata_next[LSB_THR_RSV_HI +: 3] = thr_rsv_hi_reg;
        rdata_next[LSB_THR_RSV_LO +: 3] = thr_rsv_lo_reg;
        rdata_next[LSB_ENERGY_THR +: 3] = energy_thr_reg;
      end
      ADDR_MISC_CONFIG_FOUR: begin
        rdata_next[BIT_MISC_CONFIG_FOUR_RSV]            = misc_config_four_rsv8_reg;
        rdata_next[BIT_INT_TEST]            = int_test_reg;
        rdata_next[LSB_NEG_TIMER +: 2]      = neg_timer_reg;
        rdata_next[LSB_RSV_MISC_CONFIG_FOUR +: 4]       = RSV_MISC_CONFIG_FOUR_VALUE;
        rdata_next[BIT_MIRROR]              = mirror_reg;
      end
      ADDR_REDUCED_GMII_CONTROL: begin
        rdata_next[BIT_RGMII_EN]            = mac_reg.rgmii_enable;
        rdata_next[LSB_RX_HALF +: 2]        = mac_reg.rx_fifo_half_level;
        rdata_next[LSB_TX_HALF +: 2]        = mac_reg.tx_fifo_half_level;
        rdata_next[BIT_TX_SKEW]             = mac_reg.tx_clock_skew_select;
        rdata_next[BIT_RX_SKEW]             = mac_reg.rx_clock_skew_select;
      end
      ADDR_IRQ_STATUS: rdata_next[4:0] = irq_status_reg;
      ADDR_IRQ_MASK:   rdata_next[4:0] = irq_mask_reg;
      default:         bad_addr = 1'b1;
    endcase
  end

  // One wait state: pready rises one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= access & bad_addr;
      if (rd) begin
        prdata <= rdata_next;
      end
    end
  end

  // Cause latches have their own process, so a write to the register never touches them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= 5'h00;
    end else begin
      cause_reg <= cause_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_drop_reg <= 1'b0;
      fast_en_reg    <= 1'b0;
      src_sel_reg    <= 5'h00;
    end else begin
      if (wr && paddr == ADDR_LINK_DROP_CONFIG) begin
        force_drop_reg <= pwdata[BIT_FORCE_DROP];
        fast_en_reg    <= pwdata[BIT_FAST_DROP_EN];
        src_sel_reg    <= pwdata[4:0];
      end
    end
  end

  // Straps are sampled on the first clock after reset release, never inside the reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // A write in the strap cycle is lost; software must start on the second edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_thr_reg <= RST_ENERGY_THR;
      thr_rsv_hi_reg <= RST_THR_RSV;
      thr_rsv_lo_reg <= RST_THR_RSV;
    end else if (!strap_done_reg) begin
      energy_thr_reg <= strap_fast_drop ? RST_ENERGY_THR_STRAP : RST_ENERGY_THR;
    end else if (wr && paddr == ADDR_LINK_DROP_THRESHOLDS) begin
      thr_rsv_hi_reg <= pwdata[LSB_THR_RSV_HI +: 3];
      thr_rsv_lo_reg <= pwdata[LSB_THR_RSV_LO +: 3];
      energy_thr_reg <= pwdata[LSB_ENERGY_THR +: 3];
    end
  end

  // Reserved bits 4 to 1 hold no storage; they read back as a constant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_config_four_rsv8_reg <= 1'b0;
      int_test_reg  <= 1'b0;
      neg_timer_reg <= RST_NEG_TIMER;
      mirror_reg    <= 1'b0;
    end else if (!strap_done_reg) begin
      int_test_reg <= strap_int_test;
      mirror_reg   <= strap_mirror;
    end else if (wr && paddr == ADDR_MISC_CONFIG_FOUR) begin
      misc_config_four_rsv8_reg <= pwdata[BIT_MISC_CONFIG_FOUR_RSV];
      int_test_reg  <= pwdata[BIT_INT_TEST];
      neg_timer_reg <= pwdata[LSB_NEG_TIMER +: 2];
      mirror_reg    <= pwdata[BIT_MIRROR];
    end
  end

  // Reset gives the fixed-package value; the package option or the strap sets it one edge later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_reg <= '{RST_RGMII_EN, RST_HALF_LEVEL, RST_HALF_LEVEL, 1'b0, 1'b0};
    end else if (!strap_done_reg) begin
      mac_reg.rgmii_enable <= package_fixed_rgmii | strap_rgmii_en;
    end else if (wr && paddr == ADDR_REDUCED_GMII_CONTROL) begin
      mac_reg.rgmii_enable         <= pwdata[BIT_RGMII_EN];
      mac_reg.rx_fifo_half_level   <= pwdata[LSB_RX_HALF +: 2];
      mac_reg.tx_fifo_half_level   <= pwdata[LSB_TX_HALF +: 2];
      mac_reg.tx_clock_skew_select <= pwdata[BIT_TX_SKEW];
      mac_reg.rx_clock_skew_select <= pwdata[BIT_RX_SKEW];
    end
  end

  // Interrupt status: set wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 5'h00;
    end else if (wr && paddr == ADDR_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~pwdata[4:0]) | fired;
    end else begin
      irq_status_reg <= irq_status_reg | fired;
    end
  end

  // Mask bits only gate the output; status still records every event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= 5'h00;
    end else if (wr && paddr == ADDR_IRQ_MASK) begin
      irq_mask_reg <= pwdata[4:0];
    end
  end

  // Every output is registered so that the far side never sees a decode glitch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_drop_req <= 1'b0;
    end else begin
      partner_drop_req <= force_drop_reg & no_signal;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_drop <= 1'b0;
    end else begin
      link_drop <= |fired;
    end
  end

  // The interrupt level lags the status bits by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // The timer count travels with the line settings so that both change together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cfg <= '0;
    end else begin
      line_cfg <= '{force_drop_reg, fast_en_reg, src_sel_reg, energy_thr_reg,
                    int_test_reg, mirror_reg, neg_cycles};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_cfg <= '0;
    end else begin
      mac_cfg <= mac_reg;
    end
  end
endmodule

/* File: testbench/phy_link_drop_and_mac_if_config_tb_top.sv */
// Self-checking testbench of the link drop and MAC config register bank.
`timescale 1ns/100ps
module phy_link_drop_and_mac_if_config_tb_top;
  import pldc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic up, quiet, no_sig, lnk, pdrop, ldrop, irq;
  logic [4:0] flt;
  logic s_fast, s_test, s_mirror, s_rgen, s_pkg;
  pldc_detect_s det;
  pldc_line_cfg_s lc;
  pldc_mac_cfg_s mc;
  int failures, checks;
  always #10 pclk = ~pclk;
  pldc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_fast_drop(s_fast), .strap_int_test(s_test),
    .strap_mirror(s_mirror), .strap_rgmii_en(s_rgen), .package_fixed_rgmii(s_pkg),
    .detect(det), .no_signal(no_sig), .link_up(lnk), .line_cfg(lc), .mac_cfg(mc),
    .partner_drop_req(pdrop), .link_drop(ldrop), .irq(irq));
  pldc_line_model u_line (.pclk(pclk), .up_cmd(up), .quiet_cmd(quiet), .fault_cmd(flt),
    .detect(det), .no_signal(no_sig), .link_up(lnk));
  task tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Entered just after an edge; request held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      tally_and_finish;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task tnc(input logic [1:0] c, input int n);
    apb(1'b1, ADDR_MISC_CONFIG_FOUR, {25'h0, c, 5'h0});
    cyc(2);
    chk(lc.negotiation_cycles, 32'(n));
  endtask
  task t_reset;
    rc(ADDR_LINK_DROP_THRESHOLDS, 32'h0222);
    rc(ADDR_MISC_CONFIG_FOUR, 32'h00b1);
    rc(ADDR_REDUCED_GMII_CONTROL, 32'h00d0);
    rc(ADDR_LINK_DROP_CONFIG, 32'h0);
    chk({25'h0, mc}, 32'h68);
  endtask
  task t_rw;
    apb(1'b1, ADDR_MISC_CONFIG_FOUR, 32'hffff);
    rc(ADDR_MISC_CONFIG_FOUR, 32'h01f1);
    apb(1'b1, ADDR_MISC_CONFIG_FOUR, 32'h0);
    rc(ADDR_MISC_CONFIG_FOUR, 32'h0010);
    chk({lc.internal_test_select, lc.mirror_mode_select}, 32'h0);
    tnc(2'h0, CYC_NEG_00);
    tnc(2'h1, CYC_NEG_01);
    tnc(2'h2, CYC_NEG_10);
    tnc(2'h3, CYC_NEG_11);
    apb(1'b1, ADDR_REDUCED_GMII_CONTROL, 32'hffff);
    rc(ADDR_REDUCED_GMII_CONTROL, 32'h00fb);
    chk({25'h0, mc}, 32'h7f);
    apb(1'b1, ADDR_LINK_DROP_THRESHOLDS, 32'hffff);
    rc(ADDR_LINK_DROP_THRESHOLDS, 32'h0777);
    apb(1'b1, ADDR_LINK_DROP_THRESHOLDS, 32'h1);
    rc(ADDR_LINK_DROP_THRESHOLDS, 32'h0001);
    rc(12'hff0, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task t_drop;
    up <= 1'b1;
    cyc(3);
    apb(1'b1, ADDR_LINK_DROP_CONFIG, 32'h401f);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      flt <= 5'(1 << i);
      cyc(4);
      chk({31'h0, ldrop}, 32'h1);
      flt <= 5'h0;
      cyc(3);
      chk({31'h0, irq}, 32'h1);
      rc(ADDR_IRQ_STATUS, 32'(1 << i));
      rc(ADDR_LINK_DROP_CONFIG, 32'h401f | 32'(1 << (8 + i)));
      rc(ADDR_LINK_DROP_CONFIG, 32'h401f);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1f);
      chk({31'h0, irq}, 32'h0);
    end
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    flt <= 5'h2;
    cyc(6);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_LINK_DROP_CONFIG, 32'h4000);
    flt <= 5'h1f;
    cyc(4);
    chk({31'h0, ldrop}, 32'h0);
    flt <= 5'h0;
    apb(1'b1, ADDR_LINK_DROP_CONFIG, 32'h8000);
    quiet <= 1'b1;
    cyc(3);
    chk({31'h0, pdrop}, 32'h1);
    quiet <= 1'b0;
    cyc(3);
    chk({31'h0, pdrop}, 32'h0);
  endtask
  // Mid-run reset with every strap low: the strap-driven defaults must follow.
  task t_restrap;
    quiet <= 1'b1;
    s_fast <= 1'b0;
    s_test <= 1'b0;
    s_mirror <= 1'b0;
    s_rgen <= 1'b0;
    s_pkg <= 1'b0;
    cyc(3);
    presetn <= 1'b0;
    cyc(2);
    chk({31'h0, pdrop}, 32'h0);
    chk(lc.negotiation_cycles, 32'h0);
    presetn <= 1'b1;
    cyc(3);
    rc(ADDR_LINK_DROP_THRESHOLDS, 32'h0221);
    rc(ADDR_MISC_CONFIG_FOUR, 32'h0030);
    rc(ADDR_REDUCED_GMII_CONTROL, 32'h0050);
    rc(ADDR_LINK_DROP_CONFIG, 32'h0);
    chk({25'h0, mc}, 32'h28);
    chk({31'h0, pdrop}, 32'h0);
    quiet <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    up = 1'b0;
    quiet = 1'b0;
    flt = 5'h0;
    s_fast = 1'b1;
    s_test = 1'b1;
    s_mirror = 1'b1;
    s_rgen = 1'b0;
    s_pkg = 1'b1;
    failures = 0;
    checks = 0;
    cyc(5);
    presetn <= 1'b1;
    cyc(3);
    t_reset;
    t_rw;
    t_drop;
    t_restrap;
    tally_and_finish;
  end
endmodule

/* File: testbench/pldc_chk.sv */
// Checker with bus and link drop properties of the register bank.
`timescale 1ns/100ps
module pldc_chk (
  // Bus.
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // Line side.
  input wire pldc_pkg::pldc_detect_s   detect,
  input wire logic                     no_signal,
  input wire logic                     link_up,
  input wire pldc_pkg::pldc_line_cfg_s line_cfg,
  input wire logic                     partner_drop_req,
  input wire logic                     link_drop
);
  import pldc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_one; psel && penable && !pready |=> pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("late ready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read data");
  property p_upper; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_pdrop;
    line_cfg.force_partner_drop && no_signal ##1 line_cfg.force_partner_drop |-> partner_drop_req;
  endproperty
  a_pdrop: assert property (p_pdrop) else $error("no partner drop");
  property p_quiet; !no_signal |=> !partner_drop_req; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious partner drop");
  property p_en_gate; !line_cfg.fast_drop_enable [*2] |-> !link_drop; endproperty
  a_en_gate: assert property (p_en_gate) else $error("drop while disabled");
  property p_src_gate; line_cfg.drop_source_select == 5'h0 [*2] |-> !link_drop; endproperty
  a_src_gate: assert property (p_src_gate) else $error("drop without source");
  property p_rx_err;
    link_up && detect.receive_errors ##1
      line_cfg.fast_drop_enable && line_cfg.drop_source_select[3] |-> link_drop;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("missed drop");
  property p_energy;
    link_up && detect.energy_level == 8'h00 ##1 line_cfg.fast_drop_enable &&
      line_cfg.drop_source_select[0] && line_cfg.energy_loss_threshold != 3'h0 |-> link_drop;
  endproperty
  a_energy: assert property (p_energy) else $error("missed energy drop");
endmodule
bind pldc_regs pldc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .detect(detect), .no_signal(no_signal), .link_up(link_up),
  .line_cfg(line_cfg), .partner_drop_req(partner_drop_req), .link_drop(link_drop));

/* File: testbench/pldc_line_model.sv */
// Behavioural line-side detector model feeding the drop criteria.
`timescale 1ns/100ps
module pldc_line_model (
  // Commands.
  input  wire logic              pclk,
  input  wire logic              up_cmd,
  input  wire logic              quiet_cmd,
  input  wire logic [4:0]        fault_cmd,
  // Detector outputs.
  output pldc_pkg::pldc_detect_s detect,
  output logic                   no_signal,
  output logic                   link_up
);
  import pldc_pkg::*;
  // Outputs lag commands by one cycle, as a detector needs time to decide.
  always_ff @(posedge pclk) begin
    link_up   <= up_cmd;
    no_signal <= quiet_cmd;
    detect    <= {fault_cmd[4:1], (fault_cmd[0] ? 8'h00 : 8'hc0)};
  end
endmodule
